// >>> sat_alu_defines.vh
/*
 * constants for the signed saturating add/subtract unit: operation codes,
 * status bit positions and lane widths.
 * assumes the pipeline decodes instructions into these operation codes.
 */
`ifndef SAT_ALU_DEFINES_VH
`define SAT_ALU_DEFINES_VH

// ****************************************
// operation codes
// ****************************************
`define OP_W 4
`define OP_SAT_ADD_WORD 4'h0
`define OP_SAT_SUB_WORD 4'h1
`define OP_SAT_ADD_HALVES 4'h2
`define OP_SAT_SUB_HALVES 4'h3
`define OP_SAT_ADD_BYTES 4'h4
`define OP_SAT_SUB_BYTES 4'h5
`define OP_SAT_ADD_SUB_EXCHANGE 4'h6
`define OP_SAT_SUB_ADD_EXCHANGE 4'h7
`define OP_SAT_DOUBLE_ADD 4'h8
`define OP_SAT_DOUBLE_SUB 4'h9

// ****************************************
// status register layout and reset values
// ****************************************
`define STATUS_W 5
`define STATUS_SAT_BIT 0
`define STATUS_V_BIT 1
`define STATUS_C_BIT 2
`define STATUS_Z_BIT 3
`define STATUS_N_BIT 4
`define STATUS_RESET 5'h00

// ****************************************
// widths and result latency
// ****************************************
`define WORD_W 32
`define HALF_W 16
`define BYTE_W 8
`define REG_IDX_W 4
`define RESULT_LATENCY 1

`endif

// >>> sat_clamp.v
/*
 * signed clamp of a (W+1)-bit exact value into W bits, with a flag that
 * says the value had to be changed.
 * assumes the input is an exact sum, difference or doubling in W+1 bits.
 */
module sat_clamp #(
    parameter W = 8
) (
    input wire [W:0] exact,
    output wire [W-1:0] clamped,
    output wire saturated
);

    wire too_high;
    wire too_low;

    // top two bits disagree only when the value left the W-bit range
    assign too_high = ~exact[W] & exact[W-1];
    assign too_low = exact[W] & ~exact[W-1];
    assign saturated = too_high | too_low;
    assign clamped = too_high ? {1'b0, {(W-1){1'b1}}} :
                     too_low ? {1'b1, {(W-1){1'b0}}} :
                     exact[W-1:0];

endmodule // sat_clamp

// >>> sat_lane_addsub.v
/*
 * one signed lane: add or subtract two W-bit values and clamp the result.
 * assumes the caller picks the lane operands and the direction.
 */
module sat_lane_addsub #(
    parameter W = 8
) (
    input wire [W-1:0] a,
    input wire [W-1:0] b,
    input wire subtract,
    output wire [W-1:0] result,
    output wire saturated
);

    wire [W:0] a_ext;
    wire [W:0] b_ext;
    wire [W:0] exact;

    assign a_ext = {a[W-1], a};
    assign b_ext = {b[W-1], b};
    // one extra bit holds the exact result of either direction
    assign exact = subtract ? (a_ext - b_ext) : (a_ext + b_ext);

    sat_clamp #(.W(W)) u_clamp (
        .exact(exact),
        .clamped(result),
        .saturated(saturated)
    );

endmodule // sat_lane_addsub

// >>> sat_alu.v
/*
 * signed saturating add/subtract execution unit: word, halfword lanes,
 * byte lanes, exchange pair and doubling pair, with the sticky
 * saturation bit and the condition flags held here.
 * assumes the pipeline presents one decoded operation per cycle with its
 * condition already evaluated, and keeps stack pointer and program
 * counter out of the register fields.
 * assumes unknown operation codes may arrive; they are dropped here.
 * assumes a low clock enable stalls the whole pipeline, so every
 * register here holds its value while it is low.
 * assumes status and flag writes come from other instructions and are
 * never raised by this unit.
 */
`include "sat_alu_defines.vh"

module sat_alu (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire op_valid,
    input wire [`OP_W-1:0] op_code,
    input wire cond_pass,
    input wire [`WORD_W-1:0] first_operand,
    input wire [`WORD_W-1:0] second_operand,
    input wire [`REG_IDX_W-1:0] first_operand_register,
    input wire dest_present,
    input wire [`REG_IDX_W-1:0] dest_register,
    input wire status_write_instruction,
    input wire [`STATUS_W-1:0] status_write_data,
    input wire flags_write,
    input wire [`STATUS_W-2:0] flags_write_data,
    output wire [`STATUS_W-1:0] status_read_data,
    output reg result_valid,
    output reg [`REG_IDX_W-1:0] result_register,
    output reg [`WORD_W-1:0] result_data,
    output wire sat_flag
);

    // ****************************************
    // decode
    // ****************************************
    reg is_word;
    reg is_halves;
    reg is_bytes;
    reg is_exch;
    reg is_double;
    reg do_sub;
    wire op_known;
    wire fire;

    // op classes; do_sub gives the direction, the top lane's for exchange
    always @* begin
        is_word = 1'b0;
        is_halves = 1'b0;
        is_bytes = 1'b0;
        is_exch = 1'b0;
        is_double = 1'b0;
        do_sub = 1'b0;
        case (op_code)
            `OP_SAT_ADD_WORD: begin
                is_word = 1'b1;
            end
            `OP_SAT_SUB_WORD: begin
                is_word = 1'b1;
                do_sub = 1'b1;
            end
            `OP_SAT_ADD_HALVES: begin
                is_halves = 1'b1;
            end
            `OP_SAT_SUB_HALVES: begin
                is_halves = 1'b1;
                do_sub = 1'b1;
            end
            `OP_SAT_ADD_BYTES: begin
                is_bytes = 1'b1;
            end
            `OP_SAT_SUB_BYTES: begin
                is_bytes = 1'b1;
                do_sub = 1'b1;
            end
            `OP_SAT_ADD_SUB_EXCHANGE: begin
                is_exch = 1'b1;
            end
            `OP_SAT_SUB_ADD_EXCHANGE: begin
                is_exch = 1'b1;
                do_sub = 1'b1;
            end
            `OP_SAT_DOUBLE_ADD: begin
                is_double = 1'b1;
            end
            `OP_SAT_DOUBLE_SUB: begin
                is_double = 1'b1;
                do_sub = 1'b1;
            end
            default: begin
                // no class set, so op_known stays low
                is_word = 1'b0;
            end
        endcase
    end

    assign op_known = is_word | is_halves | is_bytes | is_exch | is_double;
    // unknown codes are dropped rather than writing garbage back
    assign fire = clk_en & op_valid & cond_pass & op_known;

    // ****************************************
    // byte lanes
    // ****************************************
    wire [`WORD_W-1:0] bytes_res;

    // lane clamp flags stay open: lane forms never touch the sticky bit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
            sat_lane_addsub #(.W(`BYTE_W)) u_lane (
                .a(first_operand[gi*`BYTE_W +: `BYTE_W]),
                .b(second_operand[gi*`BYTE_W +: `BYTE_W]),
                .subtract(do_sub),
                .result(bytes_res[gi*`BYTE_W +: `BYTE_W]),
                .saturated()
            );
        end
    endgenerate

    // ****************************************
    // halfword lanes, shared by plain and exchange forms
    // ****************************************
    reg [`HALF_W-1:0] hi_a;
    reg [`HALF_W-1:0] hi_b;
    reg hi_sub;
    reg [`HALF_W-1:0] lo_a;
    reg [`HALF_W-1:0] lo_b;
    reg lo_sub;
    wire [`HALF_W-1:0] hi_res;
    wire [`HALF_W-1:0] lo_res;

    // top lane keeps the operation's direction in every form
    always @* begin
        hi_a = first_operand[31:16];
        hi_sub = do_sub;
        if (is_exch) begin
            // exchange pairs the top of the first with the bottom of the second
            hi_b = second_operand[15:0];
        end else begin
            hi_b = second_operand[31:16];
        end
    end

    // bottom lane runs the opposite direction under exchange
    always @* begin
        lo_a = first_operand[15:0];
        if (is_exch) begin
            lo_b = second_operand[31:16];
            lo_sub = ~do_sub;
        end else begin
            lo_b = second_operand[15:0];
            lo_sub = do_sub;
        end
    end

    // two lanes with different operand routes, so kept as two instances
    sat_lane_addsub #(.W(`HALF_W)) u_hi (
        .a(hi_a),
        .b(hi_b),
        .subtract(hi_sub),
        .result(hi_res),
        .saturated()
    );

    sat_lane_addsub #(.W(`HALF_W)) u_lo (
        .a(lo_a),
        .b(lo_b),
        .subtract(lo_sub),
        .result(lo_res),
        .saturated()
    );

    // ****************************************
    // word path with optional doubling step
    // ****************************************
    wire [`WORD_W:0] dbl_exact;
    wire [`WORD_W-1:0] dbl_val;
    wire dbl_sat;
    wire [`WORD_W-1:0] word_b;
    wire [`WORD_W-1:0] word_res;
    wire word_sat;

    // doubling is exact in 33 bits, so one clamp covers the first step
    assign dbl_exact = {second_operand, 1'b0};

    sat_clamp #(.W(`WORD_W)) u_double (
        .exact(dbl_exact),
        .clamped(dbl_val),
        .saturated(dbl_sat)
    );

    // doubling forms feed the clamped double into the same adder
    assign word_b = is_double ? dbl_val : second_operand;

    // this clamp is the second step of the doubling forms
    sat_lane_addsub #(.W(`WORD_W)) u_word (
        .a(first_operand),
        .b(word_b),
        .subtract(do_sub),
        .result(word_res),
        .saturated(word_sat)
    );

    // ****************************************
    // result select and sticky bit
    // ****************************************
    reg [`WORD_W-1:0] result_d;
    reg sets_sticky;

    always @* begin
        case (op_code)
            `OP_SAT_ADD_BYTES, `OP_SAT_SUB_BYTES: begin
                result_d = bytes_res;
            end
            `OP_SAT_ADD_HALVES, `OP_SAT_SUB_HALVES,
            `OP_SAT_ADD_SUB_EXCHANGE, `OP_SAT_SUB_ADD_EXCHANGE: begin
                result_d = {hi_res, lo_res};
            end
            default: begin
                // word and doubling forms share the 32-bit adder
                result_d = word_res;
            end
        endcase
    end

    always @* begin
        case (op_code)
            `OP_SAT_ADD_WORD, `OP_SAT_SUB_WORD: begin
                sets_sticky = word_sat;
            end
            `OP_SAT_DOUBLE_ADD, `OP_SAT_DOUBLE_SUB: begin
                // either the doubling or the final step may clamp
                sets_sticky = dbl_sat | word_sat;
            end
            default: begin
                // lane forms are left out on purpose, even when a lane clamps
                sets_sticky = 1'b0;
            end
        endcase
    end

    // ****************************************
    // status bits
    // ****************************************
    // one constant seeds both the condition flags and the sticky bit
    localparam [`STATUS_W-1:0] STATUS_RESET_VAL = `STATUS_RESET;

    reg sat_q;
    reg sat_d;
    reg [`STATUS_W-2:0] cond_flags_q;
    reg [`STATUS_W-2:0] cond_flags_d;

    always @* begin
        sat_d = sat_q;
        cond_flags_d = cond_flags_q;
        if (status_write_instruction) begin
            sat_d = status_write_data[`STATUS_SAT_BIT];
            cond_flags_d = status_write_data[`STATUS_W-1:1];
        end else if (flags_write) begin
            // condition flags only come from outside this unit's operations
            cond_flags_d = flags_write_data;
        end
        // applied last, so a set beats a clear in the same cycle
        if (fire & sets_sticky) begin
            sat_d = 1'b1;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sat_q <= STATUS_RESET_VAL[`STATUS_SAT_BIT];
            cond_flags_q <= STATUS_RESET_VAL[`STATUS_W-1:1];
        end else if (clk_en) begin
            sat_q <= sat_d;
            cond_flags_q <= cond_flags_d;
        end
    end

    assign status_read_data = {cond_flags_q, sat_q};
    assign sat_flag = sat_q;

    // ****************************************
    // write-back register
    // ****************************************
    reg result_valid_d;
    reg [`REG_IDX_W-1:0] result_register_d;
    reg [`WORD_W-1:0] result_data_d;

    // index and data hold between results, so a late reader still sees them
    always @* begin
        result_valid_d = fire;
        result_register_d = result_register;
        result_data_d = result_data;
        if (fire) begin
            result_data_d = result_d;
            if (dest_present) begin
                result_register_d = dest_register;
            end else begin
                result_register_d = first_operand_register;
            end
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_valid <= 1'b0;
            result_register <= {`REG_IDX_W{1'b0}};
            result_data <= {`WORD_W{1'b0}};
        end else if (clk_en) begin
            result_valid <= result_valid_d;
            result_register <= result_register_d;
            result_data <= result_data_d;
        end
    end

endmodule // sat_alu

// >>> sat_alu_sva.sv
/* checker for the saturating unit: answer timing, write-back index,
   word clamp, sticky bit and condition flags.
   assumes it is bound into sat_alu and sees only that module's ports. */
`include "sat_alu_defines.vh"
module sat_alu_sva (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire op_valid,
    input wire [`OP_W-1:0] op_code,
    input wire cond_pass,
    input wire [`WORD_W-1:0] first_operand,
    input wire [`WORD_W-1:0] second_operand,
    input wire [`REG_IDX_W-1:0] first_operand_register,
    input wire dest_present,
    input wire status_write_instruction,
    input wire [`STATUS_W-1:0] status_write_data,
    input wire flags_write,
    input wire [`STATUS_W-1:0] status_read_data,
    input wire result_valid,
    input wire [`REG_IDX_W-1:0] result_register,
    input wire [`WORD_W-1:0] result_data,
    input wire sat_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // helper logic
    // ****************************************
    wire fire = clk_en && op_valid && cond_pass && op_code <= `OP_SAT_DOUBLE_SUB;
    wire [32:0] sum = {first_operand[31], first_operand} + {second_operand[31], second_operand};
    wire ovf = sum[32] != sum[31];
    wire [31:0] sat_sum = ovf ? (sum[32] ? 32'h8000_0000 : 32'h7fff_ffff) : sum[31:0];
    wire lane_op = op_code >= `OP_SAT_ADD_HALVES && op_code <= `OP_SAT_SUB_ADD_EXCHANGE;
    wire dbl_op = op_code == `OP_SAT_DOUBLE_ADD || op_code == `OP_SAT_DOUBLE_SUB;
    // doubling leaves the 32-bit range when the top two bits differ
    wire dbl_ovf = second_operand[31] != second_operand[30];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_fire;
        fire;
    endsequence
    // a clear racing a saturating op loses, and a stalled cycle writes nothing
    sequence s_clear;
        clk_en && status_write_instruction && !status_write_data[0] && !fire;
    endsequence
    chk_fire_answers: assert property (s_fire |=> result_valid)
        else $error("no result after a taken operation");
    chk_skip_silent: assert property (clk_en && !fire |=> !result_valid)
        else $error("result without a taken operation");
    chk_dest_default: assert property (s_fire ##0 !dest_present |=>
        result_register == $past(first_operand_register)) else $error("wrong default index");
    chk_word_clamp: assert property (s_fire ##0 op_code == `OP_SAT_ADD_WORD |=>
        result_data == $past(sat_sum)) else $error("word add clamp wrong");
    chk_word_sticky: assert property (s_fire ##0 op_code == `OP_SAT_ADD_WORD && ovf |=> sat_flag)
        else $error("word clamp did not set sticky bit");
    chk_lane_keeps: assert property (s_fire ##0 lane_op && !status_write_instruction
        |=> $stable(sat_flag)) else $error("lane op changed sticky bit");
    chk_sticky_holds: assert property (sat_flag && !status_write_instruction |=> sat_flag)
        else $error("sticky bit dropped without status write");
    chk_clear_works: assert property (s_clear |=> !sat_flag)
        else $error("status write did not clear sticky bit");
    chk_status_read: assert property (status_read_data[`STATUS_SAT_BIT] == sat_flag)
        else $error("status read differs from sticky bit");
    chk_flags_hold: assert property (!flags_write && !status_write_instruction
        |=> $stable(status_read_data[4:1])) else $error("condition flags changed");
    chk_double_sticky: assert property (s_fire ##0 dbl_op && dbl_ovf |=> sat_flag)
        else $error("doubling clamp did not set sticky bit");
    chk_stall_holds: assert property (!clk_en |=> $stable(result_valid) &&
        $stable(result_data) && $stable(sat_flag)) else $error("state moved while stalled");
endmodule // sat_alu_sva
bind sat_alu sat_alu_sva sat_alu_sva_inst (.*);

// >>> pipe_regfile.sv
/* partner: the pipeline's register file, fed by the unit's write-back.
   assumes results arrive as a one-cycle valid pulse with index and data. */
module pipe_regfile (
    input wire core_clk,
    input wire result_valid,
    input wire [3:0] result_register,
    input wire [31:0] result_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] regs [0:15];
    // ****************************************
    // write-back
    // ****************************************
    // taken on the pulse only, so held outputs are not written twice
    always @(posedge core_clk) begin
        if (result_valid) begin
            regs[result_register] <= result_data;
        end
    end
endmodule // pipe_regfile

// >>> testbench.sv
/* directed testbench for the saturating unit.
   assumes the unit answers one cycle after a taken operation. */
`include "sat_alu_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, op_valid = 1'h0, cond_pass = 1'h1;
    logic [3:0] op_code = 4'h0, first_operand_register = 4'h1, dest_register = 4'h2;
    logic [31:0] first_operand = 32'h0000_0000, second_operand = 32'h0000_0000;
    logic dest_present = 1'h1, status_write_instruction = 1'h0, flags_write = 1'h0;
    logic [4:0] status_write_data = 5'h00;
    logic [3:0] flags_write_data = 4'h0;
    wire [4:0] status_read_data;
    wire result_valid, sat_flag;
    wire [3:0] result_register;
    wire [31:0] result_data;
    int errors = 0, tests_run = 0;
    sat_alu sat_alu_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .op_valid(op_valid), .op_code(op_code), .cond_pass(cond_pass),
        .first_operand(first_operand), .second_operand(second_operand),
        .first_operand_register(first_operand_register), .dest_present(dest_present),
        .dest_register(dest_register), .status_write_instruction(status_write_instruction),
        .status_write_data(status_write_data), .flags_write(flags_write),
        .flags_write_data(flags_write_data), .status_read_data(status_read_data),
        .result_valid(result_valid), .result_register(result_register),
        .result_data(result_data), .sat_flag(sat_flag));
    pipe_regfile pipe_regfile_inst (.core_clk(core_clk), .result_valid(result_valid),
        .result_register(result_register), .result_data(result_data));
    initial forever #12.5 core_clk = ~core_clk;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // a refused op leaves data and flag as they were, so callers pass old values
    task automatic go(input logic [3:0] op, input logic [31:0] a, b, exp, input logic q);
        @(posedge core_clk);
        op_valid <= 1'h1;
        op_code <= op;
        first_operand <= a;
        second_operand <= b;
        @(posedge core_clk);
        op_valid <= 1'h0;
        #1;
        chk("result_valid", cond_pass & clk_en & (op <= `OP_SAT_DOUBLE_SUB), result_valid);
        chk("result_data", exp, result_data);
        chk("sat_flag", q, sat_flag);
    endtask
    task automatic st(input logic [4:0] d);
        @(posedge core_clk);
        status_write_instruction <= 1'h1;
        status_write_data <= d;
        @(posedge core_clk);
        status_write_instruction <= 1'h0;
        #1;
        chk("status_read_data", d, status_read_data);
    endtask
    task automatic end_of_test;
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_word;
        st(5'h00);
        go(`OP_SAT_ADD_WORD,32'h0000_0001,32'h0000_0002,32'h0000_0003,1'h0);
        chk("result_register", 4'h2, result_register);
        go(`OP_SAT_ADD_WORD,32'h7fff_ffff,32'h0000_0001,32'h7fff_ffff,1'h1);
        go(`OP_SAT_ADD_WORD,32'h0000_0001,32'h0000_0001,32'h0000_0002,1'h1);
        st(5'h00);
        go(`OP_SAT_SUB_WORD,32'h8000_0000,32'h0000_0001,32'h8000_0000,1'h1);
    endtask
    task automatic t_lanes;
        st(5'h00);
        go(`OP_SAT_ADD_BYTES,32'h7f80_01ff,32'h01ff_01ff,32'h7f80_02fe,1'h0);
        go(`OP_SAT_SUB_BYTES,32'h807f_0500,32'h01ff_0780,32'h807f_fe7f,1'h0);
        go(`OP_SAT_ADD_HALVES,32'h7fff_8000,32'h0001_ffff,32'h7fff_8000,1'h0);
        go(`OP_SAT_SUB_HALVES,32'h8000_0003,32'h0001_0005,32'h8000_fffe,1'h0);
    endtask
    task automatic t_exchange;
        go(`OP_SAT_ADD_SUB_EXCHANGE,32'h0010_0020,32'h0003_0005,32'h0015_001d,1'h0);
        go(`OP_SAT_ADD_SUB_EXCHANGE,32'h7ff0_8005,32'h0006_0020,32'h7fff_8000,1'h0);
        go(`OP_SAT_SUB_ADD_EXCHANGE,32'h0010_0020,32'h0003_0005,32'h000b_0023,1'h0);
        go(`OP_SAT_SUB_ADD_EXCHANGE,32'h8005_7ff0,32'h0020_0006,32'h8000_7fff,1'h0);
    endtask
    task automatic t_double;
        go(`OP_SAT_DOUBLE_ADD,32'h0000_0001,32'h0000_0003,32'h0000_0007,1'h0);
        go(`OP_SAT_DOUBLE_ADD,32'h0000_0000,32'h4000_0000,32'h7fff_ffff,1'h1);
        st(5'h00);
        go(`OP_SAT_DOUBLE_ADD,32'h7fff_ffff,32'h0000_0001,32'h7fff_ffff,1'h1);
        st(5'h00);
        go(`OP_SAT_DOUBLE_SUB,32'h0000_0010,32'h0000_0003,32'h0000_000a,1'h0);
        go(`OP_SAT_DOUBLE_SUB,32'h0000_0000,32'hc000_0000,32'h7fff_ffff,1'h1);
    endtask
    task automatic t_cond;
        st(5'h00);
        @(posedge core_clk);
        flags_write <= 1'h1;
        flags_write_data <= 4'ha;
        first_operand_register <= 4'h5;
        dest_present <= 1'h0;
        @(posedge core_clk);
        flags_write <= 1'h0;
        go(`OP_SAT_ADD_WORD,32'h0000_0004,32'h0000_0005,32'h0000_0009,1'h0);
        chk("result_register", 4'h5, result_register);
        @(posedge core_clk);
        cond_pass <= 1'h0;
        go(`OP_SAT_ADD_WORD,32'h7fff_ffff,32'h0000_0001,32'h0000_0009,1'h0);
        chk("reg_file", 32'h0000_0009, pipe_regfile_inst.regs[5]);
        @(posedge core_clk);
        cond_pass <= 1'h1;
        clk_en <= 1'h0;
        go(`OP_SAT_SUB_WORD,32'h8000_0000,32'h0000_0001,32'h0000_0009,1'h0);
        @(posedge core_clk);
        clk_en <= 1'h1;
        go(`OP_SAT_DOUBLE_SUB,32'h8000_0000,32'h0000_0001,32'h8000_0000,1'h1);
        go(4'hf,32'h7fff_ffff,32'h0000_0001,32'h8000_0000,1'h1);
        chk("status_read_data", 5'h15, status_read_data);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        t_word;
        t_lanes;
        t_exchange;
        t_double;
        t_cond;
        end_of_test;
    end
    // about 66 cycles of traffic; this limit leaves wide margin
    initial begin
        #20000;
        errors++;
        end_of_test;
    end
endmodule // testbench
